//--- rtl/tsp_pkg.sv
// Constants for the training and set-point mode register block.
// Assumes mode register addresses are six bits and operands eight bits.
package tsp_pkg;

  // ----------------------------------------------------------------
  // Mode register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CA_REF = 6'h0c;
  localparam logic [5:0] ADDR_CTRL   = 6'h0d;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_CBT_BIT   = 0;
  localparam int CTRL_RPT_BIT   = 1;
  localparam int CTRL_VRO_BIT   = 2;
  localparam int CTRL_FAST_BIT  = 3;
  localparam int CTRL_RRO_BIT   = 4;
  localparam int CTRL_DMD_BIT   = 5;
  localparam int CTRL_WRSEL_BIT = 6;
  localparam int CTRL_OPSEL_BIT = 7;

  // ----------------------------------------------------------------
  // Reference setting register layout
  // ----------------------------------------------------------------
  localparam int REF_RANGE_BIT = 6;
  localparam int REF_CODE_MSB  = 5;
  localparam int REF_WIDTH     = 7;

  // ----------------------------------------------------------------
  // Reset values and code limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [6:0] REF_RESET    = 7'h5d;
  localparam logic [5:0] REF_CODE_MAX = 6'h32;

  // ----------------------------------------------------------------
  // Refresh-rate report codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RR_CODE_A   = 3'h1;
  localparam logic [2:0] RR_CODE_B   = 3'h2;
  localparam logic [2:0] RR_CODE_SUB = 3'h3;

  // ----------------------------------------------------------------
  // Command bus training states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_NORMAL  = 3'b001,
    ST_CBT     = 3'b010,
    ST_CBT_CAP = 3'b100
  } tsp_state_type;

endpackage

//--- rtl/tsp_sp_copy.sv
// One set-point copy of the command/address reference setting.
// Assumes the parent decodes the write strobe for this copy only.
`timescale 1ns/1ps
`default_nettype none

module tsp_sp_copy
  import tsp_pkg::*;
(
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Write port.
  input  wire logic                 wr_en,
  input  wire logic [REF_WIDTH-1:0] wr_data,
  // Stored setting.
  output logic      [REF_WIDTH-1:0] ref_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_q <= REF_RESET;
    end else if (wr_en) begin
      ref_q <= wr_data;
    end
  end

endmodule

`default_nettype wire

//--- rtl/tsp_mode_regs.sv
// Training and frequency set-point mode registers of the DRAM die.
// Assumes mode register commands arrive decoded on sys_clk, while CKE
// and the CA pins are asynchronous and pass a two-flop synchroniser.
//
// Functional notes
// - Codes above 110010 flagged reserved.
// - Bit 6 selects reference range.
// - Separate reference copy per set point.
// - Control bit 0 enters command training.
// - Training with CKE low echoes CA on DQ.
// - Bit 1 enables read preamble training.
// - Reference output uses DQ6 and DQ7.
// - Reference output shows operating set point.
// - Bit 3 selects fast-settling reference.
// - Refresh option applies only if feature set.
// - Option cleared maps 001/010 to 011.
// - Self-refresh compensation ignores refresh option.
// - Bit 5 set disables data masking.
// - Writes go to write-selected copy.
// - Operation uses operating-selected copy.
// - Reads come from write-selected copy.
// - Inactive copy never affects operation.
// - Range held until overwritten or reset.
`timescale 1ns/1ps
`default_nettype none

module tsp_mode_regs
  import tsp_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Decoded mode register commands.
  input  wire logic       mrw_valid,
  input  wire logic       mrr_valid,
  input  wire logic [5:0] mr_addr,
  input  wire logic [7:0] mrw_data,
  output logic [7:0]      mrr_data_q,
  output logic            mrr_done_q,
  // Asynchronous pins.
  input  wire logic       cke,
  input  wire logic [5:0] ca,
  // Data bus during training.
  output logic [7:0]      dq_out_q,
  output logic [7:0]      dq_oe_q,
  output logic            cmd_ignore_q,
  // Mode outputs.
  output logic            read_preamble_training_q,
  output logic            reference_fast_settle_q,
  output logic            data_mask_enable_q,
  output logic            operating_set_point_q,
  // Active reference setting and probe outputs.
  output logic [5:0]      ca_reference_level_q,
  output logic            ca_reference_range_q,
  output logic            ca_reference_legal_q,
  output logic            probe_dq6_en_q,
  output logic            probe_dq7_en_q,
  // Refresh-rate report and masked write check.
  input  wire logic       feature_rr_option,
  input  wire logic [2:0] raw_refresh_code,
  input  wire logic [2:0] raw_temp_compensated_self_refresh_code,
  output logic [2:0]      refresh_rate_report_q,
  output logic [2:0]      temp_compensated_self_refresh_code_q,
  input  wire logic       masked_wr_cmd,
  output logic            masked_wr_illegal_q
);

  // ----------------------------------------------------------------
  // Helper
  // ----------------------------------------------------------------

  // Picks one of the two set-point copies.
  function automatic logic [REF_WIDTH-1:0] pick_copy(
    input logic [REF_WIDTH-1:0] c0,
    input logic [REF_WIDTH-1:0] c1,
    input logic                 sel
  );
    pick_copy = sel ? c1 : c0;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       cke_s1_q;
  logic       cke_s2_q;
  logic [5:0] ca_s1_q;
  logic [5:0] ca_s2_q;

  // The first stage feeds only the second, so metastability stays put.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cke_s1_q <= 1'b0;
      cke_s2_q <= 1'b0;
      ca_s1_q  <= 6'h00;
      ca_s2_q  <= 6'h00;
    end else begin
      cke_s1_q <= cke;
      cke_s2_q <= cke_s1_q;
      ca_s1_q  <= ca;
      ca_s2_q  <= ca_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Training state machine
  // ----------------------------------------------------------------
  tsp_state_type state_q;
  tsp_state_type state_d;
  logic [7:0]    ctrl_q;
  logic [7:0]    ctrl_d;

  // Commands are dropped while the CA bus is being echoed.
  wire capturing = (state_q == ST_CBT_CAP);
  wire wr_hit    = mrw_valid && !capturing;
  wire ctrl_wr   = wr_hit && (mr_addr == ADDR_CTRL);
  wire ref_wr    = wr_hit && (mr_addr == ADDR_CA_REF);
  wire cbt_bit   = ctrl_q[CTRL_CBT_BIT];

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (cbt_bit) begin
          state_d = ST_CBT;
        end
      end
      ST_CBT: begin
        if (!cbt_bit) begin
          state_d = ST_NORMAL;
        end else if (!cke_s2_q) begin
          state_d = ST_CBT_CAP;
        end
      end
      ST_CBT_CAP: begin
        if (cke_s2_q) begin
          state_d = ST_CBT;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  assign ctrl_d = ctrl_wr ? mrw_data : ctrl_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  wire wr_sel = ctrl_q[CTRL_WRSEL_BIT];
  wire op_sel = ctrl_q[CTRL_OPSEL_BIT];

  // ----------------------------------------------------------------
  // Set-point copies of the reference setting
  // ----------------------------------------------------------------
  logic [REF_WIDTH-1:0] copy_ref [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_copy
      wire copy_wr = ref_wr && (wr_sel == 1'(gi));
      tsp_sp_copy u_copy (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (copy_wr),
        .wr_data (mrw_data[REF_WIDTH-1:0]),
        .ref_q   (copy_ref[gi])
      );
    end
  endgenerate

  // reads come from the write-selected copy, which may be the other one.
  wire [REF_WIDTH-1:0] op_ref = pick_copy(copy_ref[0], copy_ref[1], op_sel);
  wire [REF_WIDTH-1:0] rd_ref = pick_copy(copy_ref[0], copy_ref[1], wr_sel);

  wire code_legal = (op_ref[REF_CODE_MSB:0] <= REF_CODE_MAX);

  // ----------------------------------------------------------------
  // Mode register read
  // ----------------------------------------------------------------

  // The control register is write-only and unmapped addresses read zero.
  wire [7:0] rd_word = (mr_addr == ADDR_CA_REF) ? {1'b0, rd_ref} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mrr_data_q <= 8'h00;
      mrr_done_q <= 1'b0;
    end else begin
      mrr_done_q <= mrr_valid && !capturing;
      mrr_data_q <= (mrr_valid && !capturing) ? rd_word : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Command bus training data path
  // ----------------------------------------------------------------

  // echo CA onto DQ, ignore commands.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_out_q     <= 8'h00;
      dq_oe_q      <= 8'h00;
      cmd_ignore_q <= 1'b0;
    end else begin
      cmd_ignore_q <= (state_d == ST_CBT_CAP);
      dq_oe_q      <= (state_d == ST_CBT_CAP) ? 8'h3f : 8'h00;
      dq_out_q     <= (state_d == ST_CBT_CAP) ? {2'b00, ca_s2_q} : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Mode and reference outputs
  // ----------------------------------------------------------------

  // option honoured only with feature bit.
  // substitute 011 for 001 and 010.
  wire rr_sub = feature_rr_option && !ctrl_q[CTRL_RRO_BIT] &&
                ((raw_refresh_code == RR_CODE_A) ||
                 (raw_refresh_code == RR_CODE_B));
  wire [2:0] rr_code = rr_sub ? RR_CODE_SUB : raw_refresh_code;

  // Registered so every mode output stays glitch free at the pins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_preamble_training_q <= 1'b0;
      reference_fast_settle_q  <= 1'b0;
      data_mask_enable_q       <= 1'b1;
      operating_set_point_q    <= 1'b0;
      ca_reference_level_q     <= REF_RESET[REF_CODE_MSB:0];
      ca_reference_range_q     <= REF_RESET[REF_RANGE_BIT];
      ca_reference_legal_q     <= 1'b1;
      probe_dq6_en_q           <= 1'b0;
      probe_dq7_en_q           <= 1'b0;
      refresh_rate_report_q    <= 3'h0;
      temp_compensated_self_refresh_code_q              <= 3'h0;
      masked_wr_illegal_q      <= 1'b0;
    end else begin
      read_preamble_training_q <= ctrl_q[CTRL_RPT_BIT];
      reference_fast_settle_q  <= ctrl_q[CTRL_FAST_BIT];
      // masking off when bit 5 set.
      data_mask_enable_q       <= !ctrl_q[CTRL_DMD_BIT];
      operating_set_point_q    <= op_sel;
      // range bit of the active copy.
      ca_reference_range_q     <= op_ref[REF_RANGE_BIT];
      ca_reference_level_q     <= op_ref[REF_CODE_MSB:0];
      ca_reference_legal_q     <= code_legal;
      // the probed level is the operating copy.
      probe_dq6_en_q           <= ctrl_q[CTRL_VRO_BIT];
      probe_dq7_en_q           <= ctrl_q[CTRL_VRO_BIT];
      refresh_rate_report_q    <= rr_code;
      temp_compensated_self_refresh_code_q              <= raw_temp_compensated_self_refresh_code;
      // flag a masked write while disabled.
      masked_wr_illegal_q      <= masked_wr_cmd && ctrl_q[CTRL_DMD_BIT];
    end
  end

endmodule

`default_nettype wire

//--- bench/tsp_mode_regs_asserts.sv
// Concurrent checks on the mode register block's ports.
// Assumes one clock; attached by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module tsp_mode_regs_asserts
  import tsp_pkg::*;
(
  // Clock, reset and commands.
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       mrw_valid,
  input wire logic       mrr_valid,
  input wire logic [5:0] mr_addr,
  input wire logic [7:0] mrw_data,
  input wire logic       mrr_done_q,
  // Training link.
  input wire logic       cke,
  input wire logic [7:0] dq_out_q,
  input wire logic [7:0] dq_oe_q,
  input wire logic       cmd_ignore_q,
  // Modes and status.
  input wire logic       read_preamble_training_q,
  input wire logic       data_mask_enable_q,
  input wire logic       feature_rr_option,
  input wire logic [2:0] raw_refresh_code,
  input wire logic [2:0] raw_temp_compensated_self_refresh_code,
  input wire logic [2:0] refresh_rate_report_q,
  input wire logic [2:0] temp_compensated_self_refresh_code_q,
  input wire logic       masked_wr_cmd,
  input wire logic       masked_wr_illegal_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // Shadow of the write-only control register
  // ------------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  wire logic ctl_wr = mrw_valid && !cmd_ignore_q && mr_addr == ADDR_CTRL;
  wire logic low_code = raw_refresh_code inside {RR_CODE_A, RR_CODE_B};
  wire logic remap = feature_rr_option && !ctl_q[CTRL_RRO_BIT] && low_code;
  wire logic bad_mw = masked_wr_cmd && ctl_q[CTRL_DMD_BIT];
  wire logic rd_ok = mrr_valid && !cmd_ignore_q;
  assign ctl_d = ctl_wr ? mrw_data : ctl_q;
  // Refused writes are left out, since the device drops them too.
  always_ff @(posedge sys_clk) begin
    ctl_q <= rst ? CTRL_RESET : ctl_d;
  end
  sequence s_cke_up;
    cmd_ignore_q && $rose(cke);
  endsequence
  sequence s_ctl_wr;
    ctl_wr;
  endsequence
  property p_mode_apply;
    logic [7:0] d;
    (s_ctl_wr, d = mrw_data) |-> ##2
      (read_preamble_training_q == d[CTRL_RPT_BIT] &&
       data_mask_enable_q == !d[CTRL_DMD_BIT]);
  endproperty
  a_read_answer: assert property (
    mrr_done_q == $past(rd_ok)) else $error("read answer wrong");
  a_report_map: assert property (!$past(rst) |->
    refresh_rate_report_q == ($past(remap) ? RR_CODE_SUB :
    $past(raw_refresh_code))) else $error("refresh report wrong");
  a_temp_compensated_self_refresh_free: assert property (!$past(rst) |->
    temp_compensated_self_refresh_code_q == $past(raw_temp_compensated_self_refresh_code)) else $error("temp_compensated_self_refresh code wrong");
  a_masked_flag: assert property (!$past(rst) |->
    masked_wr_illegal_q == $past(bad_mw)) else $error("mask flag wrong");
  a_masked_idle: assert property (!$past(masked_wr_cmd) |->
    !masked_wr_illegal_q) else $error("mask flag spurious");
  a_mode_apply: assert property (p_mode_apply)
    else $error("mode output wrong");
  a_capture_drive: assert property (
    dq_oe_q == (cmd_ignore_q ? 8'h3f : 8'h00) && dq_out_q[7:6] == 2'b00)
    else $error("dq drive wrong");
  a_capture_gated: assert property (
    cmd_ignore_q |-> ctl_q[CTRL_CBT_BIT]) else $error("capture ungated");
  a_capture_exit: assert property (
    s_cke_up |-> ##[1:4] !cmd_ignore_q) else $error("capture stuck");
endmodule
bind tsp_mode_regs tsp_mode_regs_asserts u_chk (
  .sys_clk(sys_clk), .rst(rst), .mrw_valid(mrw_valid),
  .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mrw_data(mrw_data),
  .mrr_done_q(mrr_done_q), .cke(cke), .dq_out_q(dq_out_q),
  .dq_oe_q(dq_oe_q), .cmd_ignore_q(cmd_ignore_q),
  .read_preamble_training_q(read_preamble_training_q),
  .data_mask_enable_q(data_mask_enable_q),
  .feature_rr_option(feature_rr_option),
  .raw_refresh_code(raw_refresh_code), .raw_temp_compensated_self_refresh_code(raw_temp_compensated_self_refresh_code),
  .refresh_rate_report_q(refresh_rate_report_q),
  .temp_compensated_self_refresh_code_q(temp_compensated_self_refresh_code_q), .masked_wr_cmd(masked_wr_cmd),
  .masked_wr_illegal_q(masked_wr_illegal_q));
`default_nettype wire

//--- bench/tsp_ctl_model.sv
// Controller side of the command bus training link.
// Assumes the bench calls its tasks from one process at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module tsp_ctl_model (
  // Clock.
  input  wire logic       sys_clk,
  // Training link pins.
  output var  logic       cke,
  output var  logic [5:0] ca
);
  initial begin
    cke = 1'b1;
    ca  = 6'h00;
  end
  // Holds CKE low and one CA value past the synchroniser lag.
  task automatic cbt_show(input logic [5:0] v);
    @(negedge sys_clk);
    cke = 1'b0;
    ca  = v;
    repeat (6) @(negedge sys_clk);
  endtask
  // CKE raised at the same falling edge
  // CA is inverted so a stale value never looks valid outside capture.
  task automatic cbt_exit();
    @(negedge sys_clk);
    cke = 1'b1;
    ca  = ~ca;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- bench/tb_tsp_mode_regs.sv
// Self-checking bench for the training and set-point mode registers.
// Assumes the controller model drives CKE and CA; the rest is driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_tsp_mode_regs import tsp_pkg::*;;
  logic       sys_clk = 1'b0, rst = 1'b1, mrw_valid = 1'b0;
  logic       mrr_valid = 1'b0, masked_wr_cmd = 1'b0, frr = 1'b0;
  logic [5:0] mr_addr = 6'h00, level;
  logic [7:0] mrw_data = 8'h00, mrr_data_q, dq_out_q, dq_oe_q, d;
  logic [2:0] raw = 3'h0, temp_compensated_self_refresh_in = 3'h0, rr, temp_compensated_self_refresh;
  logic       mrr_done_q, cmd_ignore_q, read_preamble_training, fast, dm, opsp, range, legal;
  logic       p6, p7, illegal, cke;
  logic [5:0] ca;
  logic [5:0] pat [4] = '{6'h2a, 6'h15, 6'h3f, 6'h00};
  int         fails = 0;
  int         tests_run = 0;
  tsp_ctl_model u_ctl (.sys_clk(sys_clk), .cke(cke), .ca(ca));
  tsp_mode_regs u_dut (.sys_clk(sys_clk), .rst(rst), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mrw_data(mrw_data),
    .mrr_data_q(mrr_data_q), .mrr_done_q(mrr_done_q), .cke(cke), .ca(ca),
    .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .cmd_ignore_q(cmd_ignore_q),
    .read_preamble_training_q(read_preamble_training), .reference_fast_settle_q(fast),
    .data_mask_enable_q(dm), .operating_set_point_q(opsp),
    .ca_reference_level_q(level), .ca_reference_range_q(range),
    .ca_reference_legal_q(legal), .probe_dq6_en_q(p6), .probe_dq7_en_q(p7),
    .feature_rr_option(frr), .raw_refresh_code(raw),
    .raw_temp_compensated_self_refresh_code(temp_compensated_self_refresh_in), .refresh_rate_report_q(rr),
    .temp_compensated_self_refresh_code_q(temp_compensated_self_refresh), .masked_wr_cmd(masked_wr_cmd),
    .masked_wr_illegal_q(illegal));
  // Free-running 10 MHz clock.
  always #50 sys_clk = ~sys_clk;
  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes last one cycle; the idle cycle after stops back-to-back reuse.
  task automatic mrw(input logic [5:0] a, input logic [7:0] v);
    mrw_valid = 1'b1;
    mr_addr = a;
    mrw_data = v;
    @(negedge sys_clk);
    mrw_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic mrr(input logic [5:0] a, input logic [7:0] exp);
    mrr_valid = 1'b1;
    mr_addr = a;
    @(negedge sys_clk);
    mrr_valid = 1'b0;
    chk({7'h00, mrr_done_q}, 8'h01);
    chk(mrr_data_q, exp);
    @(negedge sys_clk);
  endtask
  task automatic chk_reset();
    chk({dm, opsp, read_preamble_training, fast, p6, p7, illegal, cmd_ignore_q}, 8'h80);
    chk({range, legal, level}, 8'hdd);
    mrr(ADDR_CA_REF, 8'h5d);
    mrr(ADDR_CTRL, 8'h00);
    mrr(6'h3f, 8'h00);
  endtask
  // Cuts a hang short well after the expected 130 or so cycles.
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk_reset();
    mrw(ADDR_CA_REF, 8'h12);
    mrw(ADDR_CTRL, 8'h40);
    mrw(ADDR_CA_REF, 8'hb3);
    mrr(ADDR_CA_REF, 8'h33);
    chk({range, legal, level}, 8'h52);
    mrw(ADDR_CTRL, 8'h80);
    chk({range, legal, level}, 8'h33);
    mrr(ADDR_CA_REF, 8'h12);
    mrw(ADDR_CA_REF, 8'h72);
    chk({range, legal, level}, 8'h33);
    mrr(ADDR_CA_REF, 8'h72);
    mrw(ADDR_CTRL, 8'h00);
    chk({range, legal, level}, 8'hf2);
    frr = 1'b1;
    for (int i = 1; i < 8; i++) begin
      d = 8'h01 << i;
      mrw(ADDR_CTRL, d);
      chk({opsp, 1'b0, ~dm, 1'b0, fast, p6, read_preamble_training, 1'b0}, d & 8'hae);
      chk({7'h00, p7}, {7'h00, d[2]});
      raw = i[0] ? RR_CODE_A : RR_CODE_B;
      temp_compensated_self_refresh_in = i[2:0];
      masked_wr_cmd = 1'b1;
      @(negedge sys_clk);
      masked_wr_cmd = 1'b0;
      chk({7'h00, illegal}, {7'h00, d[5]});
      chk({5'h00, rr}, {5'h00, (d[4] ? raw : RR_CODE_SUB)});
      chk({5'h00, temp_compensated_self_refresh}, {5'h00, temp_compensated_self_refresh_in});
    end
    frr = 1'b0;
    mrw(ADDR_CTRL, 8'h00);
    raw = RR_CODE_A;
    @(negedge sys_clk);
    chk({5'h00, rr}, {5'h00, RR_CODE_A});
    // The controller schedules from the reported code, not the raw one.
    frr = 1'b1;
    raw = RR_CODE_B;
    @(negedge sys_clk);
    chk({5'h00, rr}, {5'h00, RR_CODE_SUB});
    frr = 1'b0;
    u_ctl.cbt_show(6'h2a);
    chk({7'h00, cmd_ignore_q}, 8'h00);
    u_ctl.cbt_exit();
    mrw(ADDR_CTRL, 8'h01);
    for (int k = 0; k < 4; k++) begin
      u_ctl.cbt_show(pat[k]);
      chk(dq_out_q, {2'b00, pat[k]});
      chk(dq_oe_q, 8'h3f);
    end
    mrw(ADDR_CTRL, 8'h02);
    chk({7'h00, read_preamble_training}, 8'h00);
    u_ctl.cbt_exit();
    chk({7'h00, cmd_ignore_q}, 8'h00);
    mrw(ADDR_CTRL, 8'h60);
    mrw(ADDR_CA_REF, 8'h05);
    rst = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk_reset();
    // Set point 1 was written before reset and must be back to default.
    mrw(ADDR_CTRL, 8'h40);
    mrr(ADDR_CA_REF, 8'h5d);
    report_and_stop();
  end
endmodule
`default_nettype wire
